// File: hw/pfs_pkg.sv
package pfs_pkg;

    // Register byte offsets on the Wishbone bus, one aligned word each.
    localparam logic [4:0] OFF_PA_LOW = 5'h00;
    localparam logic [4:0] OFF_PA_HIGH = 5'h04;
    localparam logic [4:0] OFF_PB_LOW = 5'h08;
    localparam logic [4:0] OFF_PB_HIGH = 5'h0C;
    localparam logic [4:0] OFF_PC_LOW = 5'h10;
    localparam logic [4:0] OFF_PC_HIGH = 5'h14;
    localparam logic [4:0] OFF_PD_LOW = 5'h18;

    // Every selector clears to general I/O at reset.
    localparam logic [7:0] SEL_RESET = 8'h00;

    // Field positions of the four 2-bit pin fields in a selector.
    localparam int FIELD_PIN0 = 0;
    localparam int FIELD_PIN1 = 2;
    localparam int FIELD_PIN2 = 4;
    localparam int FIELD_PIN3 = 6;

    // Device variants, smallest first.
    localparam logic [1:0] VAR_SMALLEST = 2'h0;
    localparam logic [1:0] VAR_SECOND = 2'h1;
    localparam logic [1:0] VAR_THIRD = 2'h2;
    localparam logic [1:0] VAR_LARGEST = 2'h3;

    // Function code of one pin: the class of function it is routed to, or absent on a missing pin.
    typedef enum logic [3:0] {
        PFS_GPIO = 4'h0,
        PFS_SERIAL = 4'h1,
        PFS_TIMER = 4'h2,
        PFS_TIMER_INV = 4'h3,
        PFS_CRYSTAL = 4'h4,
        PFS_ADC = 4'h5,
        PFS_ADC_REF = 4'h6,
        PFS_TOUCH = 4'h7,
        PFS_LCD_SEG = 4'h8,
        PFS_LCD_BIAS = 4'h9,
        PFS_ABSENT = 4'hF
    } pfs_func_e;

    // One port's routing result: function class and channel number per pin.
    typedef struct packed {
        logic [7:0][3:0] func;
        logic [7:0][5:0] chan;
    } pfs_route_s;

endpackage : pfs_pkg

// File: hw/pfs_port_function_select.sv
// Operation
// - Port A bit 3: 00/11 I/O, 01 chip select, 10 crystal in.
// - Port A bit 2: 01 chip select, otherwise I/O.
// - Port A bit 1: 00/10 I/O, 01 timer 0 out, 11 bias mid level.
// - Port A bit 0: 01 SPI data out, otherwise I/O.
// - Port A bit 7: 10 touch key 12 or 20, 11 segment 7 or 15.
// - Port A bit 6: 11 second pump capacitor, otherwise I/O with timer clock, interrupt.
// - Port A bit 5: 01 inverted timer 0 out, 11 first pump capacitor.
// - Port A bit 4: 01 SPI data out, 10 crystal out, otherwise I/O.
// - Port B bit 3: 01 UART receive, 11 ADC 3, otherwise I/O with interrupt 0.
// - Port B bit 2: 01 UART transmit, 10 periodic timer out, 11 ADC 2.
// - Port B bit 1: 01 SPI clock or SCL, 11 ADC 1.
// - Port B bit 0: 01 SPI data in or SDA, 10 reference, 11 ADC 0.
// - Port B bit 7: 10 touch key 4, 11 ADC 7, otherwise I/O with interrupt 1.
// - Port B bit 6: 10 touch key 3, 11 ADC 6.
// - Port B bit 5: 10 touch key 2, 11 ADC 5.
// - Port B bit 4: 01 inverted periodic timer out, 10 key 1, 11 ADC 4.
// - Port C bits 0-3: 10 keys 5-8, 11 segments 0-3 except second variant.
// - Port C bits 4-7 absent on smallest; 10 keys 9-12, 11 segments 4-7 large.
// - Port D bits 0-3 absent on smallest; 10 keys 13-16, 11 segments 0-3 or 8-11.
module pfs_port_function_select #(
    parameter logic [1:0] VARIANT = 2'h3
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [4:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    output pfs_pkg::pfs_route_s route_a_o,
    output pfs_pkg::pfs_route_s route_b_o,
    output pfs_pkg::pfs_route_s route_c_o,
    output pfs_pkg::pfs_route_s route_d_o
);

    logic [7:0] pa_low;
    logic [7:0] pa_high;
    logic [7:0] pb_low;
    logic [7:0] pb_high;
    logic [7:0] pc_low;
    logic [7:0] pc_high;
    logic [7:0] pd_low;
    logic req;
    logic hit;
    logic wr;
    logic [31:0] next_rdata;
    logic has_upper;
    pfs_pkg::pfs_route_s next_a;
    pfs_pkg::pfs_route_s next_b;
    pfs_pkg::pfs_route_s next_c;
    pfs_pkg::pfs_route_s next_d;

    // The upper port C and the port D selectors exist on all but the smallest variant.
    assign has_upper = (VARIANT != pfs_pkg::VAR_SMALLEST);

    // A new request is taken only while no answer is standing, so ack lasts one cycle.
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    assign wr = req && wb_we_i && wb_sel_i[0];

    // Address decode; a missing selector decodes as unmapped and gets an error.
    always_comb begin
        hit = 1'b1;
        next_rdata = 32'h00000000;
        case (wb_adr_i)
            pfs_pkg::OFF_PA_LOW: next_rdata[7:0] = pa_low;
            pfs_pkg::OFF_PA_HIGH: next_rdata[7:0] = pa_high;
            pfs_pkg::OFF_PB_LOW: next_rdata[7:0] = pb_low;
            pfs_pkg::OFF_PB_HIGH: next_rdata[7:0] = pb_high;
            pfs_pkg::OFF_PC_LOW: next_rdata[7:0] = pc_low;
            pfs_pkg::OFF_PC_HIGH: begin
                hit = has_upper;
                next_rdata[7:0] = pc_high;
            end
            pfs_pkg::OFF_PD_LOW: begin
                hit = has_upper;
                next_rdata[7:0] = pd_low;
            end
            default: hit = 1'b0;
        endcase
    end

    // Bus answer: ack or err one cycle after the request is taken.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else if (ce_i) begin
            wb_ack_o <= req && hit;
            wb_err_o <= req && !hit;
            wb_dat_o <= (req && hit && !wb_we_i) ? next_rdata : 32'h00000000;
        end
    end

    // Selector storage; only byte lane 0 carries data, upper lanes are ignored.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pa_low <= pfs_pkg::SEL_RESET;
            pa_high <= pfs_pkg::SEL_RESET;
            pb_low <= pfs_pkg::SEL_RESET;
            pb_high <= pfs_pkg::SEL_RESET;
            pc_low <= pfs_pkg::SEL_RESET;
            pc_high <= pfs_pkg::SEL_RESET;
            pd_low <= pfs_pkg::SEL_RESET;
        end else if (ce_i && wr && hit) begin
            case (wb_adr_i)
                pfs_pkg::OFF_PA_LOW: pa_low <= wb_dat_i[7:0];
                pfs_pkg::OFF_PA_HIGH: pa_high <= wb_dat_i[7:0];
                pfs_pkg::OFF_PB_LOW: pb_low <= wb_dat_i[7:0];
                pfs_pkg::OFF_PB_HIGH: pb_high <= wb_dat_i[7:0];
                pfs_pkg::OFF_PC_LOW: pc_low <= wb_dat_i[7:0];
                pfs_pkg::OFF_PC_HIGH: pc_high <= wb_dat_i[7:0];
                pfs_pkg::OFF_PD_LOW: pd_low <= wb_dat_i[7:0];
                default: pa_low <= pa_low;
            endcase
        end
    end

    // Port A decode. The mux does not sequence peripherals: software must disable
    // a peripheral before moving its pin, since the switch here is immediate.
    always_comb begin
        next_a = '0;
        // Bit 0.
        case (pa_low[pfs_pkg::FIELD_PIN0 +: 2])
            2'h1: next_a.func[0] = pfs_pkg::PFS_SERIAL;
            default: next_a.func[0] = pfs_pkg::PFS_GPIO;
        endcase
        // Bit 1.
        case (pa_low[pfs_pkg::FIELD_PIN1 +: 2])
            2'h1: next_a.func[1] = pfs_pkg::PFS_TIMER;
            2'h3: next_a.func[1] = pfs_pkg::PFS_LCD_BIAS;
            default: next_a.func[1] = pfs_pkg::PFS_GPIO;
        endcase
        // Bit 2.
        case (pa_low[pfs_pkg::FIELD_PIN2 +: 2])
            2'h1: next_a.func[2] = pfs_pkg::PFS_SERIAL;
            default: next_a.func[2] = pfs_pkg::PFS_GPIO;
        endcase
        // Bit 3.
        case (pa_low[pfs_pkg::FIELD_PIN3 +: 2])
            2'h1: next_a.func[3] = pfs_pkg::PFS_SERIAL;
            2'h2: next_a.func[3] = pfs_pkg::PFS_CRYSTAL;
            default: next_a.func[3] = pfs_pkg::PFS_GPIO;
        endcase
        // Bit 4; channel 1 marks the crystal output side.
        case (pa_high[pfs_pkg::FIELD_PIN0 +: 2])
            2'h1: next_a.func[4] = pfs_pkg::PFS_SERIAL;
            2'h2: begin
                next_a.func[4] = pfs_pkg::PFS_CRYSTAL;
                next_a.chan[4] = 6'h01;
            end
            default: next_a.func[4] = pfs_pkg::PFS_GPIO;
        endcase
        // Bit 5; bias channel 1 is the first pump capacitor.
        case (pa_high[pfs_pkg::FIELD_PIN1 +: 2])
            2'h1: next_a.func[5] = pfs_pkg::PFS_TIMER_INV;
            2'h3: begin
                next_a.func[5] = pfs_pkg::PFS_LCD_BIAS;
                next_a.chan[5] = 6'h01;
            end
            default: next_a.func[5] = pfs_pkg::PFS_GPIO;
        endcase
        // Bit 6; the timer clock and interrupt listen on the I/O path.
        case (pa_high[pfs_pkg::FIELD_PIN2 +: 2])
            2'h3: begin
                next_a.func[6] = pfs_pkg::PFS_LCD_BIAS;
                next_a.chan[6] = 6'h02;
            end
            default: next_a.func[6] = pfs_pkg::PFS_GPIO;
        endcase
        // Bit 7.
        case (pa_high[pfs_pkg::FIELD_PIN3 +: 2])
            2'h2: begin
                next_a.func[7] = pfs_pkg::PFS_TOUCH;
                next_a.chan[7] = (VARIANT == pfs_pkg::VAR_SMALLEST) ? 6'h0C : 6'h14;
            end
            2'h3: begin
                next_a.func[7] = pfs_pkg::PFS_LCD_SEG;
                next_a.chan[7] = (VARIANT[1]) ? 6'h0F : 6'h07;
            end
            default: next_a.func[7] = pfs_pkg::PFS_GPIO;
        endcase
    end

    // Port B decode. Each pin reports its own number as channel, which is its
    // converter channel on code 11; touch keys replace it on the high selector.
    always_comb begin
        next_b = '0;
        for (int i = 0; i < 8; i++) begin
            next_b.chan[i] = 6'(i);
        end
        // Bit 0; SPI data input and SDA share code 01.
        case (pb_low[pfs_pkg::FIELD_PIN0 +: 2])
            2'h1: next_b.func[0] = pfs_pkg::PFS_SERIAL;
            2'h2: next_b.func[0] = pfs_pkg::PFS_ADC_REF;
            2'h3: next_b.func[0] = pfs_pkg::PFS_ADC;
            default: next_b.func[0] = pfs_pkg::PFS_GPIO;
        endcase
        // Bit 1; SPI clock and SCL share code 01.
        case (pb_low[pfs_pkg::FIELD_PIN1 +: 2])
            2'h1: next_b.func[1] = pfs_pkg::PFS_SERIAL;
            2'h3: next_b.func[1] = pfs_pkg::PFS_ADC;
            default: next_b.func[1] = pfs_pkg::PFS_GPIO;
        endcase
        // Bit 2; the capture input listens on the I/O path.
        case (pb_low[pfs_pkg::FIELD_PIN2 +: 2])
            2'h1: next_b.func[2] = pfs_pkg::PFS_SERIAL;
            2'h2: next_b.func[2] = pfs_pkg::PFS_TIMER;
            2'h3: next_b.func[2] = pfs_pkg::PFS_ADC;
            default: next_b.func[2] = pfs_pkg::PFS_GPIO;
        endcase
        // Bit 3; interrupt 0 listens on the I/O path.
        case (pb_low[pfs_pkg::FIELD_PIN3 +: 2])
            2'h1: next_b.func[3] = pfs_pkg::PFS_SERIAL;
            2'h3: next_b.func[3] = pfs_pkg::PFS_ADC;
            default: next_b.func[3] = pfs_pkg::PFS_GPIO;
        endcase
        // Bit 4; touch key 1, or the inverted periodic timer.
        case (pb_high[pfs_pkg::FIELD_PIN0 +: 2])
            2'h1: next_b.func[4] = pfs_pkg::PFS_TIMER_INV;
            2'h2: begin
                next_b.func[4] = pfs_pkg::PFS_TOUCH;
                next_b.chan[4] = 6'h01;
            end
            2'h3: next_b.func[4] = pfs_pkg::PFS_ADC;
            default: next_b.func[4] = pfs_pkg::PFS_GPIO;
        endcase
        // Bit 5; the standard timer clock listens on the I/O path.
        case (pb_high[pfs_pkg::FIELD_PIN1 +: 2])
            2'h2: begin
                next_b.func[5] = pfs_pkg::PFS_TOUCH;
                next_b.chan[5] = 6'h02;
            end
            2'h3: next_b.func[5] = pfs_pkg::PFS_ADC;
            default: next_b.func[5] = pfs_pkg::PFS_GPIO;
        endcase
        // Bit 6; the periodic timer clock listens on the I/O path.
        case (pb_high[pfs_pkg::FIELD_PIN2 +: 2])
            2'h2: begin
                next_b.func[6] = pfs_pkg::PFS_TOUCH;
                next_b.chan[6] = 6'h03;
            end
            2'h3: next_b.func[6] = pfs_pkg::PFS_ADC;
            default: next_b.func[6] = pfs_pkg::PFS_GPIO;
        endcase
        // Bit 7; interrupt 1 listens on the I/O path.
        case (pb_high[pfs_pkg::FIELD_PIN3 +: 2])
            2'h2: begin
                next_b.func[7] = pfs_pkg::PFS_TOUCH;
                next_b.chan[7] = 6'h04;
            end
            2'h3: next_b.func[7] = pfs_pkg::PFS_ADC;
            default: next_b.func[7] = pfs_pkg::PFS_GPIO;
        endcase
    end

    // Port C decode; the upper half vanishes on the smallest variant.
    always_comb begin
        next_c = '0;
        for (int k = 0; k < 4; k++) begin
            next_c.func[k] = pfs_pkg::PFS_GPIO;
            case (pc_low[2 * k +: 2])
                2'h2: begin
                    next_c.func[k] = pfs_pkg::PFS_TOUCH;
                    next_c.chan[k] = 6'(k + 5);
                end
                2'h3: begin
                    if (VARIANT != pfs_pkg::VAR_SECOND) begin
                        next_c.func[k] = pfs_pkg::PFS_LCD_SEG;
                        next_c.chan[k] = 6'(k);
                    end
                end
                default: next_c.func[k] = pfs_pkg::PFS_GPIO;
            endcase
            next_c.func[k + 4] = has_upper ? pfs_pkg::PFS_GPIO : pfs_pkg::PFS_ABSENT;
            if (has_upper && pc_high[2 * k +: 2] == 2'h2) begin
                next_c.func[k + 4] = pfs_pkg::PFS_TOUCH;
                next_c.chan[k + 4] = 6'(k + 9);
            end
            if (VARIANT[1] && pc_high[2 * k +: 2] == 2'h3) begin
                next_c.func[k + 4] = pfs_pkg::PFS_LCD_SEG;
                next_c.chan[k + 4] = 6'(k + 4);
            end
        end
    end

    // Port D decode; a missing selector leaves its four pins marked absent.
    always_comb begin
        next_d = '0;
        for (int k = 0; k < 4; k++) begin
            next_d.func[k] = has_upper ? pfs_pkg::PFS_GPIO : pfs_pkg::PFS_ABSENT;
            if (has_upper && pd_low[2 * k +: 2] == 2'h2) begin
                next_d.func[k] = pfs_pkg::PFS_TOUCH;
                next_d.chan[k] = 6'(k + 13);
            end
            if (has_upper && pd_low[2 * k +: 2] == 2'h3) begin
                next_d.func[k] = pfs_pkg::PFS_LCD_SEG;
                next_d.chan[k] = VARIANT[1] ? 6'(k + 8) : 6'(k);
            end
            // Port D bits 4 to 7 belong to another selector and stay general I/O here.
            next_d.func[k + 4] = pfs_pkg::PFS_GPIO;
        end
    end

    // Port A routing is registered, so it trails its selector by one cycle.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            route_a_o <= '0;
        end else if (ce_i) begin
            route_a_o <= next_a;
        end
    end

    // Port B routing register.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            route_b_o <= '0;
        end else if (ce_i) begin
            route_b_o <= next_b;
        end
    end

    // Port C routing register.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            route_c_o <= '0;
        end else if (ce_i) begin
            route_c_o <= next_c;
        end
    end

    // Port D routing register.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            route_d_o <= '0;
        end else if (ce_i) begin
            route_d_o <= next_d;
        end
    end

endmodule : pfs_port_function_select

// File: verification/pfs_monitor.sv
module pfs_monitor #(
    parameter logic [1:0] VARIANT = 2'h3
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [4:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_o,
    input wire logic wb_err_o,
    input wire pfs_pkg::pfs_route_s route_a_o,
    input wire pfs_pkg::pfs_route_s route_b_o,
    input wire pfs_pkg::pfs_route_s route_c_o,
    input wire pfs_pkg::pfs_route_s route_d_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] sh [8];
    logic taken;
    assign taken = wb_cyc_i && wb_stb_i && ce_i && !wb_ack_o && !wb_err_o;
    // Shadow selectors, updated at the acknowledge edge just as the routes are.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sh <= '{default: 8'h00};
        end else if (wb_ack_o && wb_we_i && wb_sel_i[0]) begin
            sh[wb_adr_i[4:2]] <= wb_dat_i[7:0];
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_taken_answer: assert property (taken |=> wb_ack_o != wb_err_o)
        else $error("request not answered in one cycle");
    a_pa_spi_out: assert property (route_a_o.func[0] ==
        ((sh[0][1:0] == 2'h1) ? pfs_pkg::PFS_SERIAL : pfs_pkg::PFS_GPIO))
        else $error("port A pin 0 routing wrong");
    a_pa3_crystal: assert property (sh[0][7:6] == 2'h2 |->
        route_a_o.func[3] == pfs_pkg::PFS_CRYSTAL && route_a_o.chan[3] == 6'h00)
        else $error("port A pin 3 not on crystal input");
    a_pa4_crystal: assert property (sh[1][1:0] == 2'h2 |->
        route_a_o.func[4] == pfs_pkg::PFS_CRYSTAL && route_a_o.chan[4] == 6'h01)
        else $error("port A pin 4 not on crystal output");
    a_pa7_touch: assert property (sh[1][7:6] == 2'h2 |->
        route_a_o.func[7] == pfs_pkg::PFS_TOUCH &&
        route_a_o.chan[7] == ((VARIANT == 2'h0) ? 6'h0C : 6'h14))
        else $error("port A pin 7 touch key wrong");
    a_pa6_pump: assert property (sh[1][5:4] == 2'h3 |->
        route_a_o.func[6] == pfs_pkg::PFS_LCD_BIAS && route_a_o.chan[6] == 6'h02)
        else $error("port A pin 6 not on pump capacitor");
    a_pb3_adc: assert property (sh[2][7:6] == 2'h3 |->
        route_b_o.func[3] == pfs_pkg::PFS_ADC && route_b_o.chan[3] == 6'h03)
        else $error("port B pin 3 not on converter input");
    a_pc0_seg: assert property (sh[4][1:0] == 2'h3 |-> route_c_o.func[0] ==
        ((VARIANT == 2'h1) ? pfs_pkg::PFS_GPIO : pfs_pkg::PFS_LCD_SEG))
        else $error("port C pin 0 segment routing wrong");
    a_pd0_touch: assert property (VARIANT != 2'h0 && sh[6][1:0] == 2'h2 |->
        route_d_o.func[0] == pfs_pkg::PFS_TOUCH && route_d_o.chan[0] == 6'h0D)
        else $error("port D pin 0 touch key wrong");
    a_absent_pins: assert property (VARIANT == 2'h0 && !$past(rst_i) |->
        route_c_o.func[7:4] == {4{pfs_pkg::PFS_ABSENT}} &&
        route_d_o.func[3:0] == {4{pfs_pkg::PFS_ABSENT}})
        else $error("missing pins drive a function");
    a_missing_err: assert property (taken && VARIANT == 2'h0 &&
        (wb_adr_i == pfs_pkg::OFF_PC_HIGH || wb_adr_i == pfs_pkg::OFF_PD_LOW) |=>
        wb_err_o && !wb_ack_o)
        else $error("missing selector access not refused");
    a_freeze_hold: assert property (!ce_i |=> $stable(wb_ack_o) && $stable(route_a_o))
        else $error("state moved while clock enable low");
endmodule : pfs_monitor

bind pfs_port_function_select pfs_monitor #(.VARIANT(VARIANT)) u_mon (
    .clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_ack_o, .wb_err_o, .route_a_o, .route_b_o, .route_c_o, .route_d_o
);

// File: verification/pfs_periph_model.sv
module pfs_periph_model (
    input wire logic clk_i,
    input wire logic en_i,
    input wire pfs_pkg::pfs_route_s route_i,
    output logic clash_o
);
    timeunit 1ns;
    timeprecision 1ps;
    pfs_pkg::pfs_route_s last;
    logic clash = 1'b0;
    assign clash_o = clash;
    // An enabled peripheral must never see its pins rerouted under it.
    always @(posedge clk_i) begin
        if (en_i && route_i !== last)
            clash <= 1'b1;
        last <= route_i;
    end
endmodule : pfs_periph_model

// File: verification/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic en = 1'b0;
    logic ce = 1'b1;
    logic chk_route = 1'b0;
    logic [4:0] adr = 5'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic ack, err, clash;
    logic [7:0] sh [8];
    pfs_pkg::pfs_route_s r3 [4];
    pfs_pkg::pfs_route_s r0 [4];
    logic [639:0] routes_now;
    logic [33:0] resp_q [$];
    logic [639:0] route_q [$];
    int fail_count = 0;
    int n_compared = 0;
    integer seed = 3;
    integer k;
    assign routes_now = {r3[0], r3[1], r3[2], r3[3], r0[0], r0[1], r0[2], r0[3]};
    // Largest variant answers the bus; the smallest one listens to the same traffic.
    pfs_port_function_select #(.VARIANT(pfs_pkg::VAR_LARGEST)) DUT (
        .clk_i(clk), .rst_i(rst), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .wb_err_o(err), .route_a_o(r3[0]), .route_b_o(r3[1]), .route_c_o(r3[2]), .route_d_o(r3[3])
    );
    pfs_port_function_select #(.VARIANT(pfs_pkg::VAR_SMALLEST)) dut_small (
        .clk_i(clk), .rst_i(rst), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(), .wb_ack_o(),
        .wb_err_o(), .route_a_o(r0[0]), .route_b_o(r0[1]), .route_c_o(r0[2]), .route_d_o(r0[3])
    );
    pfs_periph_model u_periph (.clk_i(clk), .en_i(en), .route_i(r3[0]), .clash_o(clash));
    initial forever #2.5 clk = ~clk;
    // Expected function and channel of one pin for a two-bit selector code.
    function automatic logic [9:0] exp_pin(input logic [1:0] v, input int p, input int i,
                                           input logic [1:0] c);
        logic [9:0] x;
        x = {pfs_pkg::PFS_GPIO, 6'h00};
        case (p)
            0: begin
                if (c == 2'h1 && i < 6)
                    x[9:6] = (i == 1) ? pfs_pkg::PFS_TIMER :
                        (i == 5) ? pfs_pkg::PFS_TIMER_INV : pfs_pkg::PFS_SERIAL;
                if (c == 2'h2 && (i == 3 || i == 4))
                    x = {pfs_pkg::PFS_CRYSTAL, 6'(i - 3)};
                if (c == 2'h2 && i == 7)
                    x = {pfs_pkg::PFS_TOUCH, (v == 2'h0) ? 6'h0C : 6'h14};
                if (c == 2'h3 && (i == 1 || i == 5 || i == 6))
                    x = {pfs_pkg::PFS_LCD_BIAS, (i == 1) ? 6'h00 : 6'(i - 4)};
                if (c == 2'h3 && i == 7)
                    x = {pfs_pkg::PFS_LCD_SEG, (v < 2'h2) ? 6'h07 : 6'h0F};
            end
            1: begin
                x[5:0] = 6'(i);
                if (c == 2'h3)
                    x = {pfs_pkg::PFS_ADC, 6'(i)};
                else if (c == 2'h2 && i > 3)
                    x = {pfs_pkg::PFS_TOUCH, 6'(i - 3)};
                else if (c == 2'h1 && i < 5)
                    x[9:6] = (i == 4) ? pfs_pkg::PFS_TIMER_INV : pfs_pkg::PFS_SERIAL;
                else if (c == 2'h2 && i != 1 && i != 3)
                    x[9:6] = (i == 0) ? pfs_pkg::PFS_ADC_REF : pfs_pkg::PFS_TIMER;
            end
            2: begin
                if (v == 2'h0 && i > 3)
                    x[9:6] = pfs_pkg::PFS_ABSENT;
                else if (c == 2'h2)
                    x = {pfs_pkg::PFS_TOUCH, 6'(i + 5)};
                else if (c == 2'h3 && v != 2'h1)
                    x = {pfs_pkg::PFS_LCD_SEG, 6'(i)};
            end
            default: begin
                if (i < 4 && v == 2'h0)
                    x[9:6] = pfs_pkg::PFS_ABSENT;
                else if (i < 4 && c == 2'h2)
                    x = {pfs_pkg::PFS_TOUCH, 6'(i + 13)};
                else if (i < 4 && c == 2'h3)
                    x = {pfs_pkg::PFS_LCD_SEG, 6'((v == 2'h1) ? i : i + 8)};
            end
        endcase
        return x;
    endfunction : exp_pin
    function automatic pfs_pkg::pfs_route_s exp_port(input logic [1:0] v, input int p,
                                                     input logic [7:0] lo, input logic [7:0] hi);
        pfs_pkg::pfs_route_s r;
        logic [9:0] x;
        for (int i = 0; i < 8; i++) begin
            x = exp_pin(v, p, i, (i < 4) ? lo[2 * i +: 2] : hi[2 * i - 8 +: 2]);
            r.func[i] = x[9:6];
            r.chan[i] = x[5:0];
        end
        return r;
    endfunction : exp_port
    function automatic logic [639:0] exp_all();
        logic [639:0] e;
        for (int v = 0; v < 2; v++)
            for (int p = 0; p < 4; p++)
                e[80 * (7 - 4 * v - p) +: 80] = exp_port((v == 0) ? pfs_pkg::VAR_LARGEST :
                    pfs_pkg::VAR_SMALLEST, p, sh[2 * p], (p == 3) ? 8'h00 : sh[2 * p + 1]);
        return e;
    endfunction : exp_all
    task automatic cmp_bus(input logic [33:0] e, input logic [33:0] g);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %0t exp %h got %h", $time, e, g);
        end
    endtask : cmp_bus
    task automatic cmp_route(input logic [639:0] e, input logic [639:0] g);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %0t exp %h got %h", $time, e, g);
        end
    endtask : cmp_route
    // One classic cycle; notes the answer and, for writes, the routing that must follow.
    task automatic wb(input logic w, input logic [4:0] a, input logic [3:0] s, input logic [7:0] d);
        int n;
        n = 0;
        if (w && s[0] && a != 5'h1C)
            sh[a[4:2]] = d;
        resp_q.push_back({w, a == 5'h1C, w ? 32'h0 : {24'h0, sh[a[4:2]]}});
        if (w)
            route_q.push_back(exp_all());
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        wdat <= {24'($random(seed)), d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && err !== 1'b1 && n < 20);
        if (n == 20)
            fail_count++;
        cyc <= 1'b0;
        @(posedge clk);
    endtask : wb
    // Reads every offset with the peripheral enabled, so port A routing of the largest variant may not move meanwhile.
    // The clock enable stays low over the first read, which must wait until it returns.
    task automatic rd_all();
        en <= 1'b1;
        ce <= 1'b0;
        repeat (2) @(posedge clk);
        fork
            begin
                repeat (4) @(posedge clk);
                ce <= 1'b1;
            end
        join_none
        for (int i = 0; i < 8; i++)
            wb(1'b0, 5'(i * 4), 4'hF, 8'h00);
        en <= 1'b0;
    endtask : rd_all
    always @(posedge clk) begin
        if (chk_route)
            cmp_route(route_q.pop_front(), routes_now);
        if (ack === 1'b1 || err === 1'b1)
            cmp_bus(resp_q.pop_front(), {we, err, we ? 32'h0 : rdat});
        chk_route = we && (ack === 1'b1 || err === 1'b1);
    end
    task automatic tally_and_finish();
        if (fail_count == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : tally_and_finish
    // Two passes, so the second reset lands after a full pass, with the bus idle.
    initial begin
        for (int r = 0; r < 2; r++) begin
            rst <= 1'b1;
            repeat (5) @(posedge clk);
            rst <= 1'b0;
            sh = '{default: 8'h00};
            wb(1'b1, 5'h00, 4'hE, 8'hFF);
            rd_all();
            for (int c = 0; c < 4; c++)
                for (int i = 0; i < 7; i++)
                    wb(1'b1, 5'(i * 4), 4'h1, {4{2'(c)}});
            rd_all();
            repeat (40) begin
                k = $random(seed);
                wb(1'b1, {k[2:0], 2'h0}, k[7:4], k[15:8]);
            end
            rd_all();
        end
        repeat (3) @(posedge clk);
        cmp_bus(34'h0, {33'h0, clash});
        tally_and_finish();
    end
    initial begin
        #20000;
        fail_count++;
        tally_and_finish();
    end
endmodule : tb
